// >>> cet_pkg.sv
// Purpose: shared types and constants for the core execution timing block
// Assumes: single processor clock, local bus at core frequency
// Notes:   cycle figures are counts of processor clocks
package cet_pkg;

  // instruction classes presented to the timing unit
  typedef enum logic [3:0] {
    CET_OP_ALU,        // plain single cycle op
    CET_OP_BRANCH,     // any branch
    CET_OP_MUL,        // multiply
    CET_OP_MAC,        // multiply accumulate or negative mac
    CET_OP_LOAD,       // scalar load
    CET_OP_STORE,      // scalar store
    CET_OP_STCX,       // store conditional word
    CET_OP_STRING,     // string or multiple access
    CET_OP_DIV         // divide, timing owned elsewhere
  } cet_op_type;

  // branch resolution classes
  typedef enum logic [2:0] {
    CET_BR_KNOWN_NT,   // known not taken
    CET_BR_KNOWN_T,    // known taken, target resolved
    CET_BR_KNOWN_T_UR, // known taken, target unresolved
    CET_BR_PRED_NT,    // predicted not taken
    CET_BR_PRED_T      // predicted taken
  } cet_br_type;

  // one instruction issued to the timing unit
  typedef struct packed {
    cet_op_type  op;          // instruction class
    cet_br_type  br;          // branch class
    logic        br_miss;     // prediction was wrong
    logic        br_late;     // resolved or predicted during decode
    logic        br_adj;      // no instruction between producer and branch
    logic [31:0] src_a;       // multiplier operand a
    logic [31:0] src_b;       // multiplier operand b
    logic        dep_mul;     // operand depends on in-flight multiply
    logic        acc_fwd;     // accumulate operand is previous mac result
    logic        hit;         // cache or fill buffer hit
    logic        uses_load;   // consumes data of the pending load
    logic [31:0] addr;        // byte address of string access
    logic [6:0]  nbytes;      // string length in bytes
  } cet_instr_type;

  // per instruction timing result
  typedef struct packed {
    logic       done;         // instruction retired
    logic [5:0] cycles;       // cycles charged to it
  } cet_retire_type;

  localparam logic [5:0] CET_CYC_ONE    = 6'h01; // basic cycle
  localparam logic [5:0] CET_CYC_TWO    = 6'h02; // two cycle case
  localparam logic [5:0] CET_CYC_THREE  = 6'h03; // three cycle case
  localparam logic [3:0] CET_MISS_FWD   = 4'h6;  // miss penalty, forwarding
  localparam logic [3:0] CET_MISS_NOFWD = 4'h7;  // miss penalty, no forward
  localparam logic [1:0] CET_STQ_DEPTH  = 2'h3;  // store queue entries
  localparam logic [3:0] CET_STQ_DRAIN  = 4'h6;  // cycles per queued store
  localparam logic [2:0] CET_MUL_ISS_HH = 3'h1;  // half x half issue
  localparam logic [2:0] CET_MUL_LAT_HH = 3'h2;  // half x half latency
  localparam logic [2:0] CET_MUL_ISS_HW = 3'h2;  // half x word issue
  localparam logic [2:0] CET_MUL_LAT_HW = 3'h3;  // half x word latency
  localparam logic [2:0] CET_MUL_ISS_WW = 3'h4;  // word x word issue
  localparam logic [2:0] CET_MUL_LAT_WW = 3'h5;  // word x word latency
  localparam int         CET_HALF_BITS  = 16;    // halfword width

endpackage

// >>> cet_mul_timer.sv
// Purpose: issue rate and latency of the shared multiplier
// Assumes: one operation offered per start pulse
// Notes:   computes cycle charge only, products are not formed here
`timescale 1ns/1ns
module cet_mul_timer (
  input  wire logic        clk_i,      // processor clock
  input  wire logic        sys_rst_i,  // synchronous reset
  input  wire logic        ce_i,       // clock enable
  input  wire logic        start_i,    // accept operation
  input  wire logic        is_mac_i,   // mac or negative mac
  input  wire logic [31:0] a_i,        // operand a
  input  wire logic [31:0] b_i,        // operand b
  input  wire logic        dep_i,      // depends on in-flight result
  input  wire logic        acc_fwd_i,  // accumulate chain forward
  output logic      [5:0]  cycles_o,   // cycles for this operation
  output logic             busy_o      // multiplier holds an operation
);
  import cet_pkg::*;

  logic [2:0] left;       // cycles until multiplier empties
  logic       small_a;    // operand a fits a halfword
  logic       small_b;    // operand b fits a halfword
  logic [2:0] iss;        // issue rate of this op
  logic [2:0] lat;        // latency of this op

  // upper half only sign extends the lower half
  function automatic logic is_half(input logic [31:0] v);
    is_half = (v[31:CET_HALF_BITS] == {CET_HALF_BITS{v[CET_HALF_BITS-1]}});
  endfunction

  // size detection, smaller operand steers the count
  always_comb begin
    small_a = is_half(a_i); // RULE_11
    small_b = is_half(b_i); // RULE_11
    if (is_mac_i || (small_a && small_b)) begin
      iss = CET_MUL_ISS_HH; // RULE_12 RULE_13
      lat = CET_MUL_LAT_HH;
    end else if (small_a || small_b) begin
      iss = CET_MUL_ISS_HW; // RULE_10 RULE_14
      lat = CET_MUL_LAT_HW;
    end else begin
      iss = CET_MUL_ISS_WW; // RULE_15
      lat = CET_MUL_LAT_WW;
    end
  end

  // pick issue rate or latency
  always_comb begin
    if (left != 3'h0 && (!dep_i || acc_fwd_i)) begin
      cycles_o = {3'h0, iss}; // RULE_16 RULE_17
    end else begin
      cycles_o = {3'h0, lat}; // RULE_16
    end
  end

  assign busy_o = (left != 3'h0); // RULE_09

  // occupancy of the single shared pipeline
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      left <= 3'h0;
    end else if (ce_i) begin
      if (start_i) begin
        left <= lat; // RULE_09
      end else if (left != 3'h0) begin
        left <= left - 3'h1;
      end
    end
  end
endmodule

// >>> cet_store_queue.sv
// Purpose: occupancy of the data cache store queue
// Assumes: queued stores drain to the local bus one at a time
// Notes:   holds counts only, no store data
`timescale 1ns/1ns
module cet_store_queue (
  input  wire logic       clk_i,      // processor clock
  input  wire logic       sys_rst_i,  // synchronous reset
  input  wire logic       ce_i,       // clock enable
  input  wire logic       push_i,     // store enters queue
  output logic            full_o,     // no room for another store
  output logic      [1:0] count_o     // stores held
);
  import cet_pkg::*;

  logic [1:0] count;      // entries held
  logic [1:0] next_count; // entries after this edge
  logic [3:0] drain;      // cycles left on head store
  logic       full;       // every entry taken

  // full is a flop so the port and the refusal agree in every cycle
  assign full_o  = full; // RULE_22
  assign count_o = count;

  // head store leaves when its drain ends, a new store may enter
  always_comb begin
    next_count = count;
    if (count != 2'h0 && drain == 4'h1) begin
      next_count = count - 2'h1;
    end
    if (push_i && !full) begin
      next_count = next_count + 2'h1; // RULE_22
    end
  end

  // entry count, full flag and drain timer
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      count <= 2'h0;
      full  <= 1'b0;
      drain <= 4'h0;
    end else if (ce_i) begin
      count <= next_count;
      full  <= (next_count == CET_STQ_DEPTH); // RULE_22
      if (count == 2'h0 || drain == 4'h1) begin
        drain <= CET_STQ_DRAIN;
      end else if (drain != 4'h0) begin
        drain <= drain - 4'h1;
      end
    end
  end
endmodule

// >>> cet_core_timing.sv
// Purpose: cycle timing of the in-order execution pipeline
// Assumes: local bus at core frequency, address ack in request cycle
// Notes:   each accepted instruction is charged a cycle count
//
// Function
// [RULE_01] in order; hits single cycle except noted
// [RULE_02] known not-taken branch takes one cycle
// [RULE_03] resolved taken: one early, two in decode
// [RULE_04] unresolved taken: two separated, three adjacent
// [RULE_05] correct not-taken prediction takes one cycle
// [RULE_06] mispredicted not-taken: two or three cycles
// [RULE_07] correct taken prediction: one or two cycles
// [RULE_08] mispredicted taken: two or three cycles
// [RULE_09] all multiplies share one pipelined multiplier
// [RULE_10] smaller operand found and swapped internally
// [RULE_11] sign extended word counts as halfword
// [RULE_12] mac issue one, latency two
// [RULE_13] half by half issue one, latency two
// [RULE_14] half by word issue two, latency three
// [RULE_15] word by word issue four, latency five
// [RULE_16] independent ops use issue rate, else latency; code charges latency to any op that enters an empty multiplier
// [RULE_17] accumulate chaining forwarded at issue rate
// [RULE_18] cache or fill buffer load hit one cycle
// [RULE_19] load use forwarding makes load two cycles
// [RULE_20] load miss six penalty forwarded, else seven
// [RULE_21] independent instructions continue during load miss
// [RULE_22] store misses queued, three deep, one cycle
// [RULE_23] aligned store conditional takes two cycles
// [RULE_24] string split: edges one cycle, words one
`timescale 1ns/1ns
module cet_core_timing (
  input  wire logic                   clk_i,     // processor clock
  input  wire logic                   sys_rst_i, // synchronous reset
  input  wire logic                   ce_i,      // clock enable
  input  wire logic                   valid_i,   // instruction offered
  input  wire cet_pkg::cet_instr_type instr_i,   // instruction fields
  input  wire logic                   fwd_en_i,  // operand forwarding on
  output logic                        ready_o,   // can accept instruction
  output cet_pkg::cet_retire_type     retire_o,  // retire pulse and cost
  output logic                        load_pend_o, // load miss in flight
  output logic                        stq_full_o   // store queue full
);
  import cet_pkg::*;

  typedef enum logic [1:0] {
    CET_ST_IDLE,      // accepting instructions
    CET_ST_BUSY,      // counting out multi cycle instruction
    CET_ST_WAIT_LOAD  // consumer stalled on pending load
  } cet_state_type;

  cet_state_type state;        // pipeline state
  cet_state_type next_state;   // next pipeline state
  logic [5:0]    cost;         // cycles for the offered instruction
  logic [5:0]    remain;       // cycles left on current instruction
  logic [5:0]    held_cost;    // cost latched for retire report
  logic [3:0]    load_left;    // miss penalty cycles outstanding
  logic [5:0]    mul_cycles;   // multiplier charge
  logic          mul_busy;     // multiplier occupied
  logic          stq_full;     // store queue full
  logic [1:0]    stq_count;    // stores in queue
  logic          accept;       // instruction taken this cycle
  logic          stall_load;   // consumer of pending load offered
  logic          last_load;    // previous instruction was a load hit
  logic          is_mulop;     // offered op uses multiplier
  logic          is_miss_load; // offered load misses

  // cycles for a branch from its resolution class
  function automatic logic [5:0] br_cycles(input cet_instr_type i);
    case (i.br)
      CET_BR_KNOWN_NT: br_cycles = CET_CYC_ONE; // RULE_02
      CET_BR_KNOWN_T: begin
        br_cycles = i.br_late ? CET_CYC_TWO : CET_CYC_ONE; // RULE_03
      end
      CET_BR_KNOWN_T_UR: begin
        br_cycles = i.br_adj ? CET_CYC_THREE : CET_CYC_TWO; // RULE_04
      end
      CET_BR_PRED_NT: begin
        if (!i.br_miss) begin
          br_cycles = CET_CYC_ONE; // RULE_05
        end else begin
          br_cycles = i.br_adj ? CET_CYC_THREE : CET_CYC_TWO; // RULE_06
        end
      end
      CET_BR_PRED_T: begin
        if (!i.br_miss) begin
          br_cycles = i.br_late ? CET_CYC_TWO : CET_CYC_ONE; // RULE_07
        end else begin
          br_cycles = i.br_adj ? CET_CYC_THREE : CET_CYC_TWO; // RULE_08
        end
      end
      default: br_cycles = CET_CYC_ONE;
    endcase
  endfunction

  // cycles for a string access: leading, words, trailing
  function automatic logic [5:0] str_cycles(input cet_instr_type i);
    logic [7:0] last;
    logic [5:0] words;
    last = {6'h00, i.addr[1:0]} + {1'b0, i.nbytes} - 8'h01;
    if (i.nbytes == 7'h00) begin
      words = 6'h00;
    end else begin
      words = last[7:2] + 6'h01; // RULE_24
    end
    str_cycles = (words == 6'h00) ? CET_CYC_ONE : words;
  endfunction

  assign is_mulop     = (instr_i.op == CET_OP_MUL)
                        || (instr_i.op == CET_OP_MAC);
  assign is_miss_load = (instr_i.op == CET_OP_LOAD) && !instr_i.hit;
  assign stall_load   = instr_i.uses_load && (load_left != 4'h0); // RULE_21
  assign accept       = ce_i && valid_i && ready_o && !stall_load
                        && !(instr_i.op == CET_OP_STORE && stq_full);
  // queue flag is already a flop, shown as is so refusal is visible
  assign stq_full_o   = stq_full; // RULE_22

  // shared multiplier timing
  cet_mul_timer u_mul (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .ce_i      (ce_i),
    .start_i   (accept && is_mulop),       // RULE_09
    .is_mac_i  (instr_i.op == CET_OP_MAC),
    .a_i       (instr_i.src_a),
    .b_i       (instr_i.src_b),
    .dep_i     (instr_i.dep_mul),
    .acc_fwd_i (instr_i.acc_fwd),
    .cycles_o  (mul_cycles),
    .busy_o    (mul_busy)
  );

  // queue for store misses
  cet_store_queue u_stq (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .ce_i      (ce_i),
    .push_i    (accept && instr_i.op == CET_OP_STORE && !instr_i.hit),
    .full_o    (stq_full),
    .count_o   (stq_count)
  );

  // cost of the offered instruction
  always_comb begin
    case (instr_i.op)
      CET_OP_BRANCH: cost = br_cycles(instr_i);
      CET_OP_MUL,
      CET_OP_MAC:    cost = mul_cycles;           // RULE_12
      CET_OP_LOAD:   cost = CET_CYC_ONE;          // RULE_18 RULE_21
      CET_OP_STORE:  cost = CET_CYC_ONE;          // RULE_22
      CET_OP_STCX:   cost = CET_CYC_TWO;          // RULE_23
      CET_OP_STRING: cost = str_cycles(instr_i);  // RULE_24
      default:       cost = CET_CYC_ONE;          // RULE_01
    endcase
    // load use forwarding adds one latency cycle to the consumer
    if (last_load && instr_i.uses_load) begin
      cost = cost + CET_CYC_ONE;                  // RULE_19
    end
  end

  // state transitions
  always_comb begin
    next_state = state;
    case (state)
      CET_ST_IDLE: begin
        if (ce_i && valid_i && stall_load) begin
          next_state = CET_ST_WAIT_LOAD;          // RULE_21
        end else if (accept && cost > CET_CYC_ONE) begin
          next_state = CET_ST_BUSY;
        end
      end
      CET_ST_BUSY: begin
        if (remain == CET_CYC_ONE) begin
          next_state = CET_ST_IDLE;
        end
      end
      CET_ST_WAIT_LOAD: begin
        if (accept && cost > CET_CYC_ONE) begin
          next_state = CET_ST_BUSY;               // released consumer
        end else if (load_left == 4'h0) begin
          next_state = CET_ST_IDLE;
        end
      end
      default: next_state = CET_ST_IDLE;
    endcase
  end

  // state register, one instruction at a time keeps order
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state <= CET_ST_IDLE;
    end else if (ce_i) begin
      state <= next_state; // RULE_01
    end
  end

  // remaining cycles of a multi cycle instruction
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      remain    <= 6'h00;
      held_cost <= 6'h00;
    end else if (ce_i) begin
      if (accept) begin
        remain    <= cost - CET_CYC_ONE;
        held_cost <= cost;
      end else if (remain != 6'h00) begin
        remain <= remain - 6'h01;
      end
    end
  end

  // pending load miss penalty counter
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      load_left <= 4'h0;
    end else if (ce_i) begin
      if (accept && is_miss_load) begin
        load_left <= fwd_en_i ? CET_MISS_FWD : CET_MISS_NOFWD; // RULE_20
      end else if (load_left != 4'h0) begin
        load_left <= load_left - 4'h1;
      end
    end
  end

  // remembers a load hit for the next consumer
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      last_load <= 1'b0;
    end else if (ce_i && accept) begin
      last_load <= (instr_i.op == CET_OP_LOAD) && instr_i.hit; // RULE_19
    end
  end

  // registered outputs
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ready_o     <= 1'b1;
      retire_o    <= '0;
      load_pend_o <= 1'b0;
    end else if (ce_i) begin
      ready_o     <= (next_state == CET_ST_IDLE) ||
                     (next_state == CET_ST_WAIT_LOAD);
      load_pend_o <= (load_left > 4'h1) || (accept && is_miss_load);
      // retire once the last cycle is charged
      if (accept && cost == CET_CYC_ONE) begin
        retire_o <= '{done: 1'b1, cycles: cost};
      end else if (state == CET_ST_BUSY && remain == CET_CYC_ONE) begin
        retire_o <= '{done: 1'b1, cycles: held_cost};
      end else begin
        retire_o <= '{done: 1'b0, cycles: 6'h00};
      end
    end
  end

endmodule

// >>> cet_mem_model.sv
// Purpose: memory side of the local bus, says hit or miss per access
// Assumes: upper half of the address map is uncached
// Notes:   slow_i forces every access out onto the bus
`timescale 1ns/1ns
module cet_mem_model (
  input  wire logic [31:0] addr_i, // access address
  input  wire logic        slow_i, // answer late, over the bus
  output logic             hit_o   // served without a bus access
);
  // cached region with a prompt answer hits, all else goes to the bus
  assign hit_o = !addr_i[31] && !slow_i;
endmodule

// >>> cet_core_timing_monitor.sv
// Purpose: port level timing checks of the execution timing block
// Assumes: ce_i held high while checks matter
// Notes:   take mirrors the acceptance condition of the block
`timescale 1ns/1ns
module cet_core_timing_monitor
  import cet_pkg::*;
(
  input wire logic                   clk_i,       // processor clock
  input wire logic                   sys_rst_i,   // synchronous reset
  input wire logic                   ce_i,        // clock enable
  input wire logic                   valid_i,     // instruction offered
  input wire cet_pkg::cet_instr_type instr_i,     // instruction fields
  input wire logic                   fwd_en_i,    // forwarding on
  input wire logic                   ready_o,     // can accept
  input wire cet_pkg::cet_retire_type retire_o,   // retire and cost
  input wire logic                   load_pend_o, // miss in flight
  input wire logic                   stq_full_o   // store queue full
);
  logic       take;    // instruction accepted at this edge
  logic       br_take; // branch accepted, no load use
  logic [5:0] elapsed; // edges since the last take
  logic       prev_mac; // last take was an accumulate
  assign take = ce_i && valid_i && ready_o
    && !(instr_i.uses_load && load_pend_o)
    && !(instr_i.op == CET_OP_STORE && stq_full_o);
  assign br_take = take && instr_i.op == CET_OP_BRANCH && !instr_i.uses_load;
  // edge counter restarted by every take
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) elapsed <= 6'h0;
    else if (take) elapsed <= 6'h1;
    else if (ce_i) elapsed <= elapsed + 6'h1;
  end
  // a chained accumulate needs its predecessor still in the multiplier
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) prev_mac <= 1'b0;
    else if (take) prev_mac <= instr_i.op == CET_OP_MAC;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  AST_RETIRE_COUNT: assert property (
    retire_o.done |-> retire_o.cycles == elapsed)
    else $error("retire cost differs from edges since take");
  AST_RESET_STATE: assert property (
    $past(sys_rst_i) |-> ready_o && !retire_o.done && !load_pend_o
      && !stq_full_o)
    else $error("outputs wrong after reset");
  AST_KNOWN_NT: assert property (
    br_take && instr_i.br == CET_BR_KNOWN_NT
      |=> retire_o.done && retire_o.cycles == 6'h1)
    else $error("known not taken branch not one cycle");
  AST_TAKEN_UR_ADJ: assert property (
    br_take && instr_i.br == CET_BR_KNOWN_T_UR && instr_i.br_adj
      |=> !ready_o[*2] ##1 (retire_o.done && retire_o.cycles == 6'h3))
    else $error("adjacent unresolved taken branch not three cycles");
  AST_PRED_NT_MISS: assert property (
    br_take && instr_i.br == CET_BR_PRED_NT && instr_i.br_miss
      && !instr_i.br_adj
      |=> !ready_o ##1 (retire_o.done && retire_o.cycles == 6'h2))
    else $error("separated not taken mispredict not two cycles");
  AST_PRED_T_EARLY: assert property (
    br_take && instr_i.br == CET_BR_PRED_T && !instr_i.br_miss
      && !instr_i.br_late |=> retire_o.done && retire_o.cycles == 6'h1)
    else $error("early taken prediction not one cycle");
  AST_MAC_CHAIN: assert property (
    take && instr_i.op == CET_OP_MAC && instr_i.acc_fwd && prev_mac
      && elapsed <= 6'h2 && !instr_i.uses_load
      |=> retire_o.done && retire_o.cycles == 6'h1)
    else $error("chained accumulate not at issue rate");
  AST_MISS_FWD: assert property (
    take && instr_i.op == CET_OP_LOAD && !instr_i.hit && fwd_en_i
      |=> load_pend_o[*6] ##1 !load_pend_o)
    else $error("forwarded miss penalty not six cycles");
  AST_MISS_NOFWD: assert property (
    take && instr_i.op == CET_OP_LOAD && !instr_i.hit && !fwd_en_i
      |=> load_pend_o[*7] ##1 !load_pend_o)
    else $error("unforwarded miss penalty not seven cycles");
  AST_LOAD_WAIT: assert property (
    ce_i && valid_i && ready_o && instr_i.uses_load && load_pend_o
      |=> !retire_o.done)
    else $error("consumer of pending load retired");
  AST_STORE_Q: assert property (
    take && instr_i.op == CET_OP_STORE && !instr_i.hit
      |=> retire_o.done && retire_o.cycles == 6'h1)
    else $error("queued store not one cycle");
  // main scenarios seen
  cover property (take && instr_i.op == CET_OP_STCX);
  cover property ($rose(load_pend_o));
  cover property ($rose(stq_full_o));
endmodule
bind cet_core_timing cet_core_timing_monitor cet_core_timing_monitor_inst (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .valid_i(valid_i),
  .instr_i(instr_i), .fwd_en_i(fwd_en_i), .ready_o(ready_o),
  .retire_o(retire_o), .load_pend_o(load_pend_o), .stq_full_o(stq_full_o));

// >>> tb.sv
// Purpose: self checking bench for the execution timing block
// Assumes: one instruction offered at a time
// Notes:   branch table, random multiplies and strings, miss and queue
`timescale 1ns/1ns
module tb;
  import cet_pkg::*;
  logic           clk_i     = 1'b0; // processor clock
  logic           sys_rst_i = 1'b1; // reset
  logic           ce_i      = 1'b1; // clock enable
  logic           valid_i   = 1'b0; // offer
  logic           fwd_en_i  = 1'b1; // forwarding
  logic           mem_slow  = 1'b0; // memory answers late
  logic           mem_hit;          // memory hit flag
  logic           ready_o;          // accept
  logic           load_pend_o;      // miss pending
  logic           stq_full_o;       // queue full
  cet_instr_type  instr_i   = '0;   // instruction
  cet_retire_type retire_o;         // retire
  int             errors    = 0;    // mismatches
  int             samples_checked = 0; // comparisons
  int             cyc       = 0;    // cycles run
  int             waited;           // edges an offer waited
  always #20 clk_i = ~clk_i;
  cet_core_timing cet_core_timing_inst (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .ce_i(ce_i), .valid_i(valid_i),
    .instr_i(instr_i), .fwd_en_i(fwd_en_i), .ready_o(ready_o),
    .retire_o(retire_o), .load_pend_o(load_pend_o),
    .stq_full_o(stq_full_o));
  cet_mem_model cet_mem_model_inst (.addr_i(instr_i.addr),
    .slow_i(mem_slow), .hit_o(mem_hit));
  task automatic print_verdict();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // offer, wait for acceptance, then count edges to retire
  task automatic issue(cet_instr_type i, logic [5:0] e);
    int   n;
    logic tk;
    instr_i = i;
    valid_i = 1'b1;
    #1 if (i.op inside {CET_OP_LOAD, CET_OP_STORE}) instr_i.hit = mem_hit;
    waited = 0;
    do begin
      @(negedge clk_i);
      tk = ready_o === 1'b1 && !(i.uses_load && load_pend_o === 1'b1)
        && !(i.op == CET_OP_STORE && stq_full_o === 1'b1);
      @(posedge clk_i);
      waited++;
    end while (!tk && waited < 60);
    #2 valid_i = 1'b0;
    n = 1;
    while (retire_o.done !== 1'b1 && n < 60) begin
      @(posedge clk_i);
      #2 n++;
    end
    chk("retire edges", 32'(e), n);
    chk("retire cycles", 32'(e), 32'(retire_o.cycles));
  endtask
  task automatic idle();
    repeat (6) @(posedge clk_i);
    #2;
  endtask
  function automatic logic [5:0] br_cost(cet_instr_type i);
    case (i.br)
      CET_BR_KNOWN_NT:   return 6'h1;
      CET_BR_KNOWN_T:    return i.br_late ? 6'h2 : 6'h1;
      CET_BR_KNOWN_T_UR: return i.br_adj ? 6'h3 : 6'h2;
      CET_BR_PRED_NT:    return !i.br_miss ? 6'h1
                           : i.br_adj ? 6'h3 : 6'h2;
      default: return i.br_miss ? (i.br_adj ? 6'h3 : 6'h2)
                 : i.br_late ? 6'h2 : 6'h1;
    endcase
  endfunction
  function automatic logic half(logic [31:0] x);
    return x[31:16] === {16{x[15]}};
  endfunction
  // cost from an empty multiplier, operand order irrelevant
  function automatic logic [5:0] mul_cost(cet_instr_type i);
    if (i.op == CET_OP_MAC) return 6'h2;
    if (half(i.src_a) && half(i.src_b)) return 6'h2;
    if (half(i.src_a) || half(i.src_b)) return 6'h3;
    return 6'h5;
  endfunction
  function automatic logic [5:0] str_cost(cet_instr_type i);
    return 6'((9'(i.addr[1:0]) + 9'(i.nbytes) + 9'h3) >> 2);
  endfunction
  function automatic logic [31:0] rand_op();
    logic [31:0] v;
    v = $urandom;
    case ($urandom_range(0, 2))
      0:       return {{16{v[15]}}, v[15:0]};
      1:       return {17'h0, v[14:0]};
      default: return v;
    endcase
  endfunction
  // hang guard
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      print_verdict();
    end
  end
  initial begin
    cet_instr_type i;
    int            k;
    void'($urandom(32'h2b32));
    repeat (10) @(posedge clk_i);
    #2 sys_rst_i = 1'b0;
    chk("reset outputs", 32'h8,
      {ready_o, retire_o.done, load_pend_o, stq_full_o});
    // every branch class with every flag combination
    for (k = 0; k < 40; k++) begin
      i = '0;
      i.op = CET_OP_BRANCH;
      i.br = cet_br_type'(k / 8);
      {i.br_miss, i.br_late, i.br_adj} = 3'(k);
      issue(i, br_cost(i));
    end
    for (k = 0; k < 30; k++) begin
      i = '0;
      i.op = $urandom_range(0, 1) ? CET_OP_MAC : CET_OP_MUL;
      i.src_a = rand_op();
      i.src_b = rand_op();
      idle();
      issue(i, mul_cost(i));
    end
    idle();
    i = '0;
    i.op = CET_OP_MUL;
    i.src_a = 32'h1234_5678;
    i.src_b = 32'h8765_4321;
    issue(i, 6'h5);
    i.dep_mul = 1'b1;
    issue(i, 6'h5);
    i.dep_mul = 1'b0;
    issue(i, 6'h4);
    idle();
    i = '0;
    i.op = CET_OP_MAC;
    issue(i, 6'h2);
    i.acc_fwd = 1'b1;
    issue(i, 6'h1);
    i = '0;
    i.op = CET_OP_STCX;
    issue(i, 6'h2);
    i.op = CET_OP_LOAD;
    issue(i, 6'h1);
    i.op = CET_OP_ALU;
    i.uses_load = 1'b1;
    issue(i, 6'h2);
    for (k = 0; k < 2; k++) begin
      fwd_en_i = !k[0];
      mem_slow = 1'b1;
      i = '0;
      i.op = CET_OP_LOAD;
      issue(i, 6'h1);
      mem_slow = 1'b0;
      i.op = CET_OP_ALU;
      issue(i, 6'h1);
      chk("pending during independent op", 1, load_pend_o);
      i.uses_load = 1'b1;
      issue(i, 6'h1);
      chk("consumer held", 1, waited > 1);
    end
    // three stores back to back fill the queue
    i = '0;
    i.op = CET_OP_STORE;
    i.addr = 32'h8000_0000;
    instr_i = i;
    valid_i = 1'b1;
    #1 instr_i.hit = mem_hit;
    repeat (3) @(posedge clk_i);
    #2 valid_i = 1'b0;
    chk("queue full", 1, stq_full_o);
    issue(i, 6'h1);
    chk("store held while full", 1, waited > 1);
    // clock enable low freezes a store conditional mid count
    idle();
    i = '0;
    i.op = CET_OP_STCX;
    instr_i = i;
    valid_i = 1'b1;
    @(posedge clk_i);
    #2 valid_i = 1'b0;
    ce_i = 1'b0;
    repeat (4) @(posedge clk_i);
    #2 chk("frozen retire", 0, retire_o.done);
    ce_i = 1'b1;
    @(posedge clk_i);
    #2 chk("thawed retire", 2, retire_o.cycles);
    i = '0;
    i.op = CET_OP_STRING;
    i.addr = 32'h1;
    i.nbytes = 7'h15;
    issue(i, 6'h6);
    for (k = 0; k < 20; k++) begin
      i.addr = $urandom;
      i.nbytes = 7'($urandom_range(1, 127));
      issue(i, str_cost(i));
    end
    print_verdict();
  end
endmodule
